// >>> common/rcs_consts.vh
`ifndef RCS_CONSTS_VH
`define RCS_CONSTS_VH

// register indices; byte address is four times the index
`define RCS_IDX_RATE 12'h024
`define RCS_IDX_ERRMASK 12'h037
`define RCS_IDX_CLKGEN 12'h06C
`define RCS_IDX_DRIVE 12'h06D
`define RCS_IDX_EQSKIP 12'h073
`define RCS_IDX_LOCKIMM 12'h085
`define RCS_IDX_ERRSTAT 12'h090
`define RCS_IDX_INTMASK 12'h091
`define RCS_IDX_ANC_LO 12'h800
`define RCS_IDX_ANC_HI 12'hBFF

// field layouts and reset values
`define RCS_ERR_VALID 11'h77F
`define RCS_ERR_RST 11'h000
`define RCS_DELAY_RST 5'h00
`define RCS_DRIVE_RST 6'h2B
`define RCS_UPPER_DRV_RST 2'h2
`define RCS_FLAG_DRV_RST 2'h2
`define RCS_LOWER_DRV_RST 2'h3
`define RCS_RATE_MODE_RST 1'b1
`define RCS_EQ_BIT 9
`define RCS_LOCK_BIT 10
`define RCS_RATE_MODE_BIT 2
`define RCS_RATE_RST 3'h4
`define RCS_ANC_DEPTH 1024

// lock qualifier
`define RCS_TRS_NEEDED 2'h3
`define RCS_TRS_ONE 2'h1

// axi responses
`define RCS_RESP_OKAY 2'h0
`define RCS_RESP_SLVERR 2'h2

`endif

// >>> src/rcs_regs.v
// Summary of operation
// [RULE1] eleven-bit error mask, bit seven reserved
// [RULE2] masked flags leave global error, still reported
// [RULE3] five-bit delay offset, drives delay line
// [RULE4] upper data and pixel clock drive, reset two
// [RULE5] status pin drive field, reset two
// [RULE6] lower data drive field, reset three
// [RULE7] bit nine set skips the cable equalizer
// [RULE8] bit ten: three sync codes, aligned pair
// [RULE9] host sets immunity only in automatic rate
// [RULE10] rate mode one means automatic rate detection
// [RULE11] read-only ancillary word bank, zero after reset
// [RULE12] upper byte word high, lower byte low
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "rcs_consts.vh"

module rcs_regs (
    input wire clk,
    input wire rst,
    input wire [13:0] awaddr,
    input wire awvalid,
    output reg awready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output reg wready,
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    input wire [13:0] araddr,
    input wire arvalid,
    output reg arready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    input wire [10:0] faultFlags,
    output reg [10:0] faultReport,
    output reg globalError,
    output reg [4:0] delayOffset,
    output reg [1:0] upperDataDrive,
    output reg [1:0] flagPinDrive,
    output reg [1:0] lowerDataDrive,
    output reg equalizerSkip,
    output reg lockImmunityEnable,
    output reg rateDetectMode,
    output reg [1:0] manualRate,
    input wire trsSeen,
    input wire [3:0] trsAlign,
    input wire syncLost,
    output reg syncLock,
    input wire ancWrEn,
    input wire [9:0] ancWrAddr,
    input wire [7:0] upperByteWord,
    input wire [7:0] lowerByteWord,
    output reg irq
);

    reg [10:0] errMask_reg;
    reg [4:0] clkGen_reg;
    reg [5:0] drive_reg;
    reg eqSkip_reg;
    reg lockImm_reg;
    reg [2:0] rate_reg;
    reg [10:0] errStat_reg;
    reg [10:0] intMask_reg;
    reg [15:0] ancMem [0:`RCS_ANC_DEPTH-1];
    reg [`RCS_ANC_DEPTH-1:0] ancValid_reg;
    reg [11:0] awIdx_reg;
    reg awHeld_reg;
    reg [15:0] wData_reg;
    reg [1:0] wStrb_reg;
    reg wHeld_reg;
    reg [1:0] trsCount_reg;
    reg [3:0] lastAlign_reg;

    wire [11:0] arIdx;
    wire doWrite;
    wire wMapped;
    wire [10:0] errSet;
    wire [10:0] w1cMask;
    wire [15:0] wMerged;
    reg [15:0] rdVal;
    reg rdMapped;
    reg [15:0] curVal;

    assign arIdx = araddr[13:2];
    assign doWrite = awHeld_reg && wHeld_reg && !bvalid;
    // only reserved bit seven can never raise anything
    assign errSet = faultFlags & `RCS_ERR_VALID; // [RULE1]

    // current value of the addressed writable register, for byte merging
    always @* begin
        curVal = 16'h0000;
        case (awIdx_reg)
            `RCS_IDX_RATE: curVal = {13'h0000, rate_reg};
            `RCS_IDX_ERRMASK: curVal = {5'h00, errMask_reg};
            `RCS_IDX_CLKGEN: curVal = {11'h000, clkGen_reg};
            `RCS_IDX_DRIVE: curVal = {10'h000, drive_reg};
            `RCS_IDX_EQSKIP: curVal = {6'h00, eqSkip_reg, 9'h000};
            `RCS_IDX_LOCKIMM: curVal = {5'h00, lockImm_reg, 10'h000};
            `RCS_IDX_INTMASK: curVal = {5'h00, intMask_reg};
            default: curVal = 16'h0000;
        endcase
    end

    assign wMerged = {wStrb_reg[1] ? wData_reg[15:8] : curVal[15:8],
                      wStrb_reg[0] ? wData_reg[7:0] : curVal[7:0]};
    assign wMapped = (awIdx_reg == `RCS_IDX_RATE) || (awIdx_reg == `RCS_IDX_ERRMASK) ||
                     (awIdx_reg == `RCS_IDX_CLKGEN) || (awIdx_reg == `RCS_IDX_DRIVE) ||
                     (awIdx_reg == `RCS_IDX_EQSKIP) || (awIdx_reg == `RCS_IDX_LOCKIMM) ||
                     (awIdx_reg == `RCS_IDX_ERRSTAT) || (awIdx_reg == `RCS_IDX_INTMASK);
    // write-one-to-clear only acts on lanes actually strobed
    assign w1cMask = (doWrite && awIdx_reg == `RCS_IDX_ERRSTAT) ?
                     (wMerged[10:0] & {{3{wStrb_reg[1]}}, {8{wStrb_reg[0]}}}) : 11'h000;

    // write address and data channels, taken in either order
    always @(posedge clk) begin
        if (rst) begin
            awready <= 1'b0;
            wready <= 1'b0;
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awIdx_reg <= 12'h000;
            wData_reg <= 16'h0000;
            wStrb_reg <= 2'h0;
            bvalid <= 1'b0;
            bresp <= `RCS_RESP_OKAY;
        end else begin
            awready <= 1'b0;
            wready <= 1'b0;
            if (awvalid && !awHeld_reg && !awready) begin
                awready <= 1'b1;
                awHeld_reg <= 1'b1;
                awIdx_reg <= awaddr[13:2];
            end
            if (wvalid && !wHeld_reg && !wready) begin
                wready <= 1'b1;
                wHeld_reg <= 1'b1;
                wData_reg <= wdata[15:0];
                wStrb_reg <= wstrb[1:0];
            end
            if (doWrite) begin
                bvalid <= 1'b1;
                // ancillary bank and unmapped space refuse writes
                bresp <= wMapped ? `RCS_RESP_OKAY : `RCS_RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
            end
        end
    end

    // configuration registers
    always @(posedge clk) begin
        if (rst) begin
            errMask_reg <= `RCS_ERR_RST; // [RULE1]
            clkGen_reg <= `RCS_DELAY_RST; // [RULE3]
            drive_reg <= `RCS_DRIVE_RST; // [RULE4] [RULE5] [RULE6]
            eqSkip_reg <= 1'b0; // [RULE7]
            lockImm_reg <= 1'b0; // [RULE8]
            rate_reg <= `RCS_RATE_RST; // [RULE10]
            intMask_reg <= 11'h000;
        end else if (doWrite) begin
            case (awIdx_reg)
                `RCS_IDX_RATE: rate_reg <= wMerged[2:0];
                `RCS_IDX_ERRMASK: errMask_reg <= wMerged[10:0] & `RCS_ERR_VALID; // [RULE1]
                `RCS_IDX_CLKGEN: clkGen_reg <= wMerged[4:0]; // [RULE3]
                `RCS_IDX_DRIVE: drive_reg <= wMerged[5:0]; // [RULE4] [RULE5] [RULE6]
                `RCS_IDX_EQSKIP: eqSkip_reg <= wMerged[`RCS_EQ_BIT]; // [RULE7]
                `RCS_IDX_LOCKIMM: lockImm_reg <= wMerged[`RCS_LOCK_BIT]; // [RULE8]
                `RCS_IDX_INTMASK: intMask_reg <= wMerged[10:0] & `RCS_ERR_VALID;
                default: rate_reg <= rate_reg;
            endcase
        end
    end

    // sticky error status; a fresh fault beats a same-cycle clear
    always @(posedge clk) begin
        if (rst) begin
            errStat_reg <= 11'h000;
        end else begin
            errStat_reg <= (errStat_reg & ~w1cMask) | errSet;
        end
    end

    // ancillary word bank; data has no reset, a valid bit per word does
    always @(posedge clk) begin
        if (ancWrEn) begin
            ancMem[ancWrAddr] <= {upperByteWord, lowerByteWord}; // [RULE12]
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `RCS_ANC_DEPTH; gi = gi + 1) begin : g_anc_valid
            always @(posedge clk) begin
                if (rst) begin
                    ancValid_reg[gi] <= 1'b0; // [RULE11]
                end else if (ancWrEn && ancWrAddr == gi) begin
                    ancValid_reg[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // read decode
    always @* begin
        rdVal = 16'h0000;
        rdMapped = 1'b1;
        case (arIdx)
            `RCS_IDX_RATE: rdVal = {13'h0000, rate_reg};
            `RCS_IDX_ERRMASK: rdVal = {5'h00, errMask_reg};
            `RCS_IDX_CLKGEN: rdVal = {11'h000, clkGen_reg};
            `RCS_IDX_DRIVE: rdVal = {10'h000, drive_reg};
            `RCS_IDX_EQSKIP: rdVal = {6'h00, eqSkip_reg, 9'h000};
            `RCS_IDX_LOCKIMM: rdVal = {5'h00, lockImm_reg, 10'h000};
            `RCS_IDX_ERRSTAT: rdVal = {5'h00, errStat_reg};
            `RCS_IDX_INTMASK: rdVal = {5'h00, intMask_reg};
            default: begin
                if (arIdx >= `RCS_IDX_ANC_LO && arIdx <= `RCS_IDX_ANC_HI) begin
                    rdVal = 16'h0000; // [RULE11]
                end else begin
                    rdMapped = 1'b0;
                end
            end
        endcase
    end

    // read channel: raise rvalid together with arready, one cycle after arvalid is seen
    always @(posedge clk) begin
        if (rst) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `RCS_RESP_OKAY;
        end else begin
            arready <= 1'b0;
            if (arvalid && !arready && !rvalid) begin
                arready <= 1'b1;
                rvalid <= 1'b1;
                rresp <= rdMapped ? `RCS_RESP_OKAY : `RCS_RESP_SLVERR;
                if (arIdx >= `RCS_IDX_ANC_LO && arIdx <= `RCS_IDX_ANC_HI) begin
                    // unwritten words read zero until the engine fills them
                    rdata <= {16'h0000, ancValid_reg[arIdx[9:0]] ?
                              ancMem[arIdx[9:0]] : 16'h0000}; // [RULE11] [RULE12]
                end else begin
                    rdata <= {16'h0000, rdVal};
                end
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // video sync lock qualifier
    always @(posedge clk) begin
        if (rst || syncLost) begin
            trsCount_reg <= 2'h0;
            lastAlign_reg <= 4'h0;
            syncLock <= 1'b0;
        end else if (trsSeen) begin
            lastAlign_reg <= trsAlign;
            if (!lockImm_reg) begin
                syncLock <= 1'b1;
            end else if (trsCount_reg == `RCS_TRS_NEEDED - `RCS_TRS_ONE) begin
                // two codes behind this one: lock only when it matches the last
                if (trsAlign == lastAlign_reg) begin
                    syncLock <= 1'b1; // [RULE8]
                end
            end else begin
                // count up to two codes; a moved alignment keeps older codes counted
                trsCount_reg <= trsCount_reg + `RCS_TRS_ONE; // [RULE8]
            end
        end
    end

    // registered control and status outputs
    always @(posedge clk) begin
        if (rst) begin
            faultReport <= 11'h000;
            globalError <= 1'b0;
            delayOffset <= `RCS_DELAY_RST;
            upperDataDrive <= `RCS_UPPER_DRV_RST;
            flagPinDrive <= `RCS_FLAG_DRV_RST;
            lowerDataDrive <= `RCS_LOWER_DRV_RST;
            equalizerSkip <= 1'b0;
            lockImmunityEnable <= 1'b0;
            rateDetectMode <= `RCS_RATE_MODE_RST;
            manualRate <= 2'h0;
            irq <= 1'b0;
        end else begin
            faultReport <= errSet; // [RULE2]
            globalError <= |(errSet & ~errMask_reg); // [RULE2]
            delayOffset <= clkGen_reg; // [RULE3]
            upperDataDrive <= drive_reg[5:4]; // [RULE4]
            flagPinDrive <= drive_reg[3:2]; // [RULE5]
            lowerDataDrive <= drive_reg[1:0]; // [RULE6]
            equalizerSkip <= eqSkip_reg; // [RULE7]
            lockImmunityEnable <= lockImm_reg; // [RULE8]
            rateDetectMode <= rate_reg[`RCS_RATE_MODE_BIT]; // [RULE10]
            manualRate <= rate_reg[1:0];
            irq <= |(errStat_reg & intMask_reg);
        end
    end

endmodule // rcs_regs

// >>> dv/rcs_regs_sva.sv
`timescale 1ns/1ps
module rcs_regs_sva (
    input wire clk, rst, bvalid, bready, arvalid, arready, rvalid,
    input wire globalError, rateDetectMode, trsSeen, syncLost, syncLock,
    input wire [1:0] bresp, upperDataDrive, flagPinDrive, lowerDataDrive,
    input wire [31:0] rdata,
    input wire [10:0] faultFlags, faultReport
);
    // one clock domain, so clock and reset are given once
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_REPORT:
    assert property (!$past(rst) |-> faultReport == ($past(faultFlags) & 11'h77F))
        else $error("fault report wrong");
    AST_GERR:
    assert property (globalError |-> |($past(faultFlags) & 11'h77F))
        else $error("global error without a flag");
    AST_RST_VALUES:
    assert property ($fell(rst) |-> {upperDataDrive, flagPinDrive, lowerDataDrive} == 6'h2B
        && rateDetectMode) else $error("reset value wrong");
    AST_LOCK_CAUSE:
    assert property ($rose(syncLock) |-> $past(trsSeen)) else $error("lock without code");
    AST_LOST:
    assert property ($past(syncLost) && !$past(trsSeen) |-> !syncLock) else $error("lock kept");
    AST_WDONE:
    assert property (bvalid && bready |=> !bvalid) else $error("write answer kept");
    AST_RANS:
    assert property (arvalid && !arready && !rvalid |=> arready && rvalid)
        else $error("read not answered");
    AST_RUPPER:
    assert property (rvalid |-> rdata[31:16] == 16'h0000) else $error("read upper half set");
    // main scenarios
    cover property ($rose(syncLock));
    cover property (bvalid && bresp == 2'h2);
    cover property (globalError);
endmodule // rcs_regs_sva
bind rcs_regs rcs_regs_sva chk (.*);

// >>> dv/rcs_regs_tb.sv
`timescale 1ns/1ps
`include "rcs_consts.vh"
module rcs_regs_tb;
    localparam int RT = `RCS_IDX_RATE, EM = `RCS_IDX_ERRMASK, CG = `RCS_IDX_CLKGEN;
    localparam int DV = `RCS_IDX_DRIVE, EQ = `RCS_IDX_EQSKIP, LK = `RCS_IDX_LOCKIMM;
    localparam int ST = `RCS_IDX_ERRSTAT, IM = `RCS_IDX_INTMASK, AL = `RCS_IDX_ANC_LO;
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready;
    logic rvalid, globalError, equalizerSkip, lockImmunityEnable, rateDetectMode, trsSeen;
    logic syncLost, syncLock, ancWrEn, irq;
    logic [13:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb, trsAlign, sb;
    logic [1:0] bresp, rresp, upperDataDrive, flagPinDrive, lowerDataDrive, manualRate;
    logic [10:0] faultFlags, faultReport;
    logic [4:0] delayOffset;
    logic [9:0] ancWrAddr;
    logic [7:0] upperByteWord, lowerByteWord;
    // code steps: alignment, loss pulse, expected lock
    logic [5:0] seq[13] = '{6'h01, 6'h02, 6'h0C, 6'h0C, 6'h10, 6'h02, 6'h1C, 6'h1C, 6'h1D,
                            6'h02, 6'h20, 6'h24, 6'h25};
    int failCount, compares, m[int], wm[int], k;
    rcs_regs uut (.*);
    // 250 MHz core clock
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    task printVerdict;
        $display("errors %0d compares %0d", failCount, compares);
        if (failCount == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            failCount++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask
    // a wait that runs dry ends the run
    task tmo(input int n);
        if (n >= 50) begin
            failCount++;
            printVerdict;
        end
    endtask
    task wr(input int a, input logic [31:0] v, input logic [3:0] st, input logic [1:0] s);
        int n, lm;
        @(posedge clk);
        awaddr <= 14'(a * 4);
        wdata <= v;
        wstrb <= st;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        n = 0;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            n++;
        end while (!bvalid && n < 50);
        tmo(bvalid ? 0 : n);
        bready <= 0;
        chk("bresp", bresp, s);
        // only enabled lanes of writable bits move
        lm = {st[1] ? 8'hFF : 8'h00, st[0] ? 8'hFF : 8'h00};
        if (s == 0 && wm.exists(a)) m[a] = m[a] & ~(lm & wm[a]) | v & lm & wm[a];
    endtask
    task rd(input int a, input logic [1:0] s);
        int n;
        @(posedge clk);
        araddr <= 14'(a * 4);
        arvalid <= 1;
        rready <= 1;
        n = 0;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 0;
            n++;
        end while (!rvalid && n < 50);
        tmo(rvalid ? 0 : n);
        rready <= 0;
        chk("rresp", rresp, s);
        chk("rdata", rdata, s ? 0 : m[a]);
    endtask
    // outputs trail their registers by a cycle
    task outs;
        repeat (2) @(posedge clk);
        chk("delay", delayOffset, m[CG]);
        chk("dr", {upperDataDrive, flagPinDrive, lowerDataDrive}, m[DV]);
        chk("eqlk", {equalizerSkip, lockImmunityEnable}, {m[EQ][9], m[LK][10]});
        chk("rate", {rateDetectMode, manualRate}, m[RT]);
    endtask
    task trs(input logic [5:0] c);
        @(posedge clk);
        trsSeen <= !c[1];
        syncLost <= c[1];
        trsAlign <= c[5:2];
        @(posedge clk);
        trsSeen <= 0;
        syncLost <= 0;
        repeat (2) @(posedge clk);
        chk("lock", syncLock, c[0]);
    endtask
    task irqIs(input logic e);
        repeat (2) @(posedge clk);
        chk("irq", irq, e);
    endtask
    initial begin
        rst = 1;
        {awvalid, wvalid, bready, arvalid, rready, trsSeen, syncLost, ancWrEn} = 8'h00;
        {awaddr, araddr, wdata, wstrb, trsAlign, faultFlags, ancWrAddr} = 0;
        {upperByteWord, lowerByteWord} = 16'h0000;
        d = $urandom(45);
        wm = '{RT: 32'h7, EM: 32'h77F, CG: 32'h1F, DV: 32'h3F, EQ: 32'h200, LK: 32'h400,
               IM: 32'h77F};
        m = '{RT: 32'h4, EM: 0, CG: 0, DV: 32'h2B, EQ: 0, LK: 0, ST: 0, IM: 0};
        for (k = 0; k < 1024; k++)
            m[AL + k] = 0;
        repeat (12) @(posedge clk);
        rst <= 0;
        // reset values, then random values through random lanes
        foreach (wm[j])
            rd(j, 0);
        rd(ST, 0);
        outs;
        repeat (6) begin
            foreach (wm[j]) begin
                d = $urandom;
                sb = 4'($urandom);
                // host never leaves automatic rate while immunity is armed
                if (j == RT && m[LK][10])
                    d[2] = 1;
                if (j == LK && !m[RT][2]) begin
                    d[10] = 0;
                    sb[1] = 1;
                end
                wr(j, d, sb, 0);
                rd(j, 0);
            end
            outs;
        end
        // unmapped place and read-only bank refuse
        wr(12'h038, 32'hFFFFFFFF, 4'hF, 2);
        wr(AL, 32'hFFFFFFFF, 4'hF, 2);
        rd(12'h038, 2);
        rd(AL, 0);
        // global error sees unmasked flags only
        repeat (8) begin
            wr(EM, $urandom, 4'h3, 0);
            faultFlags <= 11'($urandom);
            repeat (3) @(posedge clk);
            chk("report", faultReport, faultFlags & 11'h77F);
            chk("gerr", globalError, |(faultFlags & ~m[EM] & 11'h77F));
        end
        // sticky status, masked, cleared by writing one
        faultFlags <= 11'h000;
        wr(ST, 32'h7FF, 4'h3, 0);
        wr(IM, 32'h1, 4'h3, 0);
        irqIs(0);
        faultFlags <= 11'h001;
        @(posedge clk);
        faultFlags <= 11'h000;
        irqIs(1);
        m[ST] = 1;
        rd(ST, 0);
        wr(IM, 0, 4'h3, 0);
        irqIs(0);
        wr(IM, 32'h1, 4'h3, 0);
        irqIs(1);
        wr(ST, 32'h1, 4'h3, 0);
        irqIs(0);
        // immunity only armed with automatic rate
        wr(RT, 32'h4, 4'h3, 0);
        wr(LK, 0, 4'h3, 0);
        foreach (seq[j]) begin
            if (j == 2)
                wr(LK, 32'h400, 4'h3, 0);
            trs(seq[j]);
        end
        // extraction engine fills words, host reads back
        for (k = 0; k < 4; k++) begin
            @(posedge clk);
            ancWrEn <= 1;
            ancWrAddr <= k == 3 ? 10'h3FF : 10'($urandom);
            upperByteWord <= 8'($urandom);
            lowerByteWord <= 8'($urandom);
            @(posedge clk);
            ancWrEn <= 0;
            m[AL + ancWrAddr] = {upperByteWord, lowerByteWord};
            rd(AL + ancWrAddr, 0);
        end
        printVerdict;
    end
endmodule // rcs_regs_tb
